// ===== rtl/bct_pkg.sv
// Shared constants for the bus cycle trace recorder.
package bct_pkg;
  // Register byte offsets.
  localparam logic [7:0] BCT_OFS_CTRL = 8'h00;
  localparam logic [7:0] BCT_OFS_STATUS = 8'h04;
  localparam logic [7:0] BCT_OFS_COUNT = 8'h08;
  localparam logic [7:0] BCT_OFS_POST = 8'h0C;
  localparam logic [7:0] BCT_OFS_RD_INDEX = 8'h10;
  localparam logic [7:0] BCT_OFS_SAMPLE_LO = 8'h14;
  localparam logic [7:0] BCT_OFS_SAMPLE_HI = 8'h18;
  // Reset values.
  localparam logic [15:0] BCT_RST_DELAY = 16'h0000;
  // Status bit positions.
  localparam int BCT_ST_CAPTURE = 0;
  localparam int BCT_ST_DELAY = 1;
  localparam int BCT_ST_FROZEN = 2;
  localparam int BCT_ST_WRAPPED = 3;
  localparam int BCT_ST_AVAIL = 4;
  localparam int BCT_ST_DELAY_MODE = 5;
  // Sample field widths.
  localparam int BCT_ADDR_W = 24;
  localparam int BCT_DATA_W = 16;
  localparam int BCT_SAMPLE_W = 51;
  // Positions of fields in the upper sample word; the lower word holds the address.
  localparam int BCT_HI_DATA = 0;
  localparam int BCT_HI_WIDTH16 = 16;
  localparam int BCT_HI_HBE_N = 17;
  localparam int BCT_HI_IFACE = 18;
  localparam int BCT_HI_DIR = 21;
  localparam int BCT_HI_VALID_N = 23;
  localparam int BCT_HI_QUEUE = 24;
  // Bus interface state codes.
  localparam logic [2:0] BCT_IF_NO_CHANGE = 3'h0;
  localparam logic [2:0] BCT_IF_NON_CPU = 3'h1;
  localparam logic [2:0] BCT_IF_INTACK = 3'h2;
  localparam logic [2:0] BCT_IF_FETCH_BYTE = 3'h3;
  localparam logic [2:0] BCT_IF_DATA_BYTE = 3'h4;
  localparam logic [2:0] BCT_IF_FETCH_WORD = 3'h5;
  localparam logic [2:0] BCT_IF_DATA_WORD = 3'h6;
  // Data bus direction codes.
  localparam logic [1:0] BCT_DIR_NONE = 2'h0;
  localparam logic [1:0] BCT_DIR_READ = 2'h1;
  localparam logic [1:0] BCT_DIR_WRITE = 2'h2;
  // Trace memory depth in address bits: four mega samples.
  localparam int BCT_MEM_AW = 22;
  typedef enum logic [3:0] {
    BCT_IDLE = 4'b0001,
    BCT_CAPTURE = 4'b0010,
    BCT_DELAY = 4'b0100,
    BCT_FROZEN = 4'b1000
  } bct_state_t;
endpackage : bct_pkg

// ===== rtl/bct_mem.sv
// Simple dual-port trace memory with registered read data.
`timescale 1ns/1ps
module bct_mem #(
  parameter int W = 51,
  parameter int AW = 22
) (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port.
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule : bct_mem

// ===== rtl/bct_buf2.sv
// Two-entry buffer with valid and ready on both sides and a flush.
`timescale 1ns/1ps
module bct_buf2 #(
  parameter int W = 51
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] ent_q [0:1];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = ent_q[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      ent_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (flush)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      rd_q <= rd_q ^ pop;
      wr_q <= wr_q ^ push;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : bct_buf2

// ===== rtl/bct_recorder.sv
// Bus cycle trace recorder: capture into circular trace memory, APB readout.
// What this block does
// - Each cycle while the program runs, until a trace stop and its delay end capture, store one bus sample in trace memory.
// - Trace memory holds up to four mega bus cycles.
// - When execution halts, the stored samples become readable, trace point or not.
// - With no conditions set, every bus cycle is captured until execution stops.
// - Capture starts the cycle the program starts and ends when it stops, or at a trace stop once its delay has run out.
// - Without delay, newest sample is index 0, older ones count down negatively.
// - With delay, the stop sample is index 0, later samples count up positively.
// - Each sample records bus width as eight or sixteen bits.
// - Each sample records the high byte enable level; low means odd address.
// - Each sample records one of seven bus interface state codes.
// - Each sample records data direction as read, write or no access.
// - Each sample records an active-low valid strobe qualifying address, data, state.
// - A full memory is overwritten oldest first, as a circular buffer.
// - Each sample records the instruction queue byte count, zero to four.
`timescale 1ns/1ps
module bct_recorder
  import bct_pkg::*;
#(
  parameter int MEM_AW = BCT_MEM_AW
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored target bus.
  input wire logic prog_running,
  input wire logic trace_stop,
  input wire logic [BCT_ADDR_W-1:0] bus_addr,
  input wire logic [BCT_DATA_W-1:0] bus_data,
  input wire logic bus_width16,
  input wire logic high_byte_enable_n,
  input wire logic [2:0] bus_iface_state,
  input wire logic [1:0] bus_dir,
  input wire logic cycle_valid_n,
  input wire logic [2:0] queue_byte_count,
  // Status pins.
  output logic capturing,
  output logic frozen
);
  localparam logic [MEM_AW:0] DEPTH = {1'b1, {MEM_AW{1'b0}}};

  bct_state_t state_q;
  bct_state_t state_d;
  logic run_q;
  logic [MEM_AW-1:0] wr_ptr_q;
  logic [MEM_AW:0] count_q;
  logic [MEM_AW-1:0] ref_q;
  logic delay_mode_q;
  logic [15:0] delay_cfg_q;
  logic [15:0] delay_cnt_q;
  logic [15:0] post_q;
  logic [MEM_AW-1:0] fetch_q;
  logic fetch_on_q;
  logic rd_pend_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic capturing_q;
  logic frozen_q;

  // Sample capture and state control.
  wire start = prog_running && !run_q;
  wire cap_state = (state_q == BCT_CAPTURE) || (state_q == BCT_DELAY);
  wire cap_en = start || (cap_state && prog_running);
  wire [MEM_AW-1:0] wr_addr = start ? {MEM_AW{1'b0}} : wr_ptr_q;
  // A stop met during the delay window is ignored, so index 0 stays on the first stop.
  wire last_delay = (state_q == BCT_DELAY) && cap_en && (delay_cnt_q == 16'h0001);
  wire [BCT_SAMPLE_W-1:0] sample = {
    queue_byte_count,
    cycle_valid_n,
    bus_dir,
    bus_iface_state,
    high_byte_enable_n,
    bus_width16,
    bus_data,
    bus_addr
  };

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      BCT_IDLE, BCT_FROZEN:
        if (start)
        begin
          state_d = BCT_CAPTURE;
        end
      BCT_CAPTURE:
        if (!prog_running)
        begin
          state_d = BCT_FROZEN;
        end
        else if (trace_stop && delay_cfg_q == 16'h0000)
        begin
          state_d = BCT_FROZEN;
        end
        else if (trace_stop)
        begin
          state_d = BCT_DELAY;
        end
      BCT_DELAY:
        if (!prog_running || last_delay)
        begin
          state_d = BCT_FROZEN;
        end
    endcase
  end

  // Start of a run resets capture; the delay count is taken at the stop sample.
  wire stop_delay = (state_q == BCT_CAPTURE) && prog_running && trace_stop
                    && (delay_cfg_q != 16'h0000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= BCT_IDLE;
      run_q <= 1'b0;
      wr_ptr_q <= '0;
      count_q <= '0;
      ref_q <= '0;
      delay_mode_q <= 1'b0;
      delay_cnt_q <= 16'h0000;
      post_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      run_q <= prog_running;
      if (cap_en)
      begin
        wr_ptr_q <= wr_addr + 1'b1;
        if (start)
        begin
          count_q <= {{MEM_AW{1'b0}}, 1'b1};
        end
        else if (count_q != DEPTH)
        begin
          count_q <= count_q + 1'b1;
        end
      end
      if (start)
      begin
        delay_mode_q <= 1'b0;
        post_q <= 16'h0000;
      end
      else if (stop_delay)
      begin
        ref_q <= wr_addr;
        delay_mode_q <= 1'b1;
        delay_cnt_q <= delay_cfg_q;
      end
      else if (state_q == BCT_DELAY && cap_en)
      begin
        delay_cnt_q <= delay_cnt_q - 16'h0001;
        post_q <= post_q + 16'h0001;
      end
    end
  end

  // Index 0 is the stop sample in delay mode, otherwise the newest sample.
  wire [MEM_AW-1:0] ref_addr = delay_mode_q ? ref_q : wr_ptr_q - 1'b1;

  // Readout path: memory feeds the two-entry buffer, APB drains it.
  wire apb_setup = psel && !penable;
  wire apb_done = psel && penable && pready_q;
  wire wr_done = apb_done && pwrite;
  wire idx_write = wr_done && (paddr == BCT_OFS_RD_INDEX) && !cap_state;
  wire buf_out_valid;
  wire buf_in_ready;
  wire [BCT_SAMPLE_W-1:0] buf_out_data;
  wire [BCT_SAMPLE_W-1:0] mem_rd_data;
  wire pop = apb_done && !pwrite && (paddr == BCT_OFS_SAMPLE_HI);
  wire readable = (state_q == BCT_FROZEN);
  wire issue = fetch_on_q && readable && !rd_pend_q && buf_in_ready && !idx_write;

  bct_mem #(
    .W(BCT_SAMPLE_W),
    .AW(MEM_AW)
  ) u_mem (
    .clk(pclk),
    .wr_en(cap_en),
    .wr_addr(wr_addr),
    .wr_data(sample),
    .rd_addr(fetch_q),
    .rd_data(mem_rd_data)
  );

  bct_buf2 #(
    .W(BCT_SAMPLE_W)
  ) u_buf (
    .clk(pclk),
    .rst_n(presetn),
    .flush(idx_write || cap_en),
    .in_valid(rd_pend_q),
    .in_ready(buf_in_ready),
    .in_data(mem_rd_data),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(buf_out_data)
  );

  // The fetcher waits for a free slot before each read, so a read in flight always fits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_q <= '0;
      fetch_on_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else if (idx_write || cap_en)
    begin
      fetch_q <= ref_addr + pwdata[MEM_AW-1:0];
      fetch_on_q <= idx_write;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      rd_pend_q <= issue;
      if (rd_pend_q)
      begin
        fetch_q <= fetch_q + 1'b1;
      end
    end
  end

  // APB register decode; reads are prepared in the setup cycle.
  wire [31:0] st_word = {26'h0, delay_mode_q, buf_out_valid && readable,
                         count_q == DEPTH, readable, state_q == BCT_DELAY,
                         cap_state};
  wire [31:0] hi_word = {5'h0, buf_out_data[BCT_SAMPLE_W-1:BCT_ADDR_W]};
  wire [31:0] lo_word = {8'h0, buf_out_data[BCT_ADDR_W-1:0]};
  wire [31:0] cnt_word = {{(31 - MEM_AW){1'b0}}, count_q};
  wire mapped = (paddr == BCT_OFS_CTRL) || (paddr == BCT_OFS_STATUS)
                || (paddr == BCT_OFS_COUNT) || (paddr == BCT_OFS_POST)
                || (paddr == BCT_OFS_RD_INDEX) || (paddr == BCT_OFS_SAMPLE_LO)
                || (paddr == BCT_OFS_SAMPLE_HI);
  wire [31:0] rd_mux = (paddr == BCT_OFS_CTRL) ? {16'h0, delay_cfg_q}
                     : (paddr == BCT_OFS_STATUS) ? st_word
                     : (paddr == BCT_OFS_COUNT) ? cnt_word
                     : (paddr == BCT_OFS_POST) ? {16'h0, post_q}
                     : (paddr == BCT_OFS_SAMPLE_LO) ? lo_word
                     : (paddr == BCT_OFS_SAMPLE_HI) ? hi_word
                     : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      delay_cfg_q <= BCT_RST_DELAY;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !mapped;
      if (apb_setup && !pwrite)
      begin
        prdata_q <= rd_mux;
      end
      if (wr_done && paddr == BCT_OFS_CTRL)
      begin
        delay_cfg_q <= pwdata[15:0];
      end
    end
  end

  // Status pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capturing_q <= 1'b0;
      frozen_q <= 1'b0;
    end
    else
    begin
      capturing_q <= (state_d == BCT_CAPTURE) || (state_d == BCT_DELAY);
      frozen_q <= (state_d == BCT_FROZEN);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign capturing = capturing_q;
  assign frozen = frozen_q;
endmodule : bct_recorder

// ===== tb/bct_recorder_monitor.sv
// Port checker for the bus cycle trace recorder.
`timescale 1ns/1ps
module bct_recorder_monitor (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Capture.
  input wire logic prog_running,
  input wire logic capturing,
  input wire logic frozen
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_run_start;
    $rose(prog_running);
  endsequence
  sequence s_run_end;
    capturing && !prog_running;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  property p_ready_only;
    pready |-> psel && penable;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_unmap;
    psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  property p_map;
    psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_start;
    s_run_start |-> ##[1:2] capturing;
  endproperty
  property p_stop;
    s_run_end |-> ##[1:2] !capturing;
  endproperty
  property p_frz_hold;
    frozen && !prog_running |=> frozen;
  endproperty
  a_answer: assert property (p_answer) else $error("No answer after setup.");
  a_ready_only: assert property (p_ready_only) else $error("Stray ready.");
  a_err: assert property (p_err) else $error("Error without ready.");
  a_unmap: assert property (p_unmap) else $error("Unmapped access accepted.");
  a_map: assert property (p_map) else $error("Mapped access refused.");
  a_start: assert property (p_start) else $error("Capture did not start.");
  a_stop: assert property (p_stop) else $error("Capture did not stop.");
  a_frz_hold: assert property (p_frz_hold) else $error("Frozen record lost.");
endmodule : bct_recorder_monitor

bind bct_recorder bct_recorder_monitor u_bct_recorder_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .prog_running(prog_running), .capturing(capturing), .frozen(frozen));

// ===== tb/bct_target_model.sv
// Target bus model: one sample per cycle, numbered from the start of each run.
`timescale 1ns/1ps
module bct_target_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control from the bench.
  input wire logic run_en,
  input wire logic [7:0] stop_k,
  // Target bus.
  output logic prog_running,
  output logic trace_stop,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_width16,
  output logic high_byte_enable_n,
  output logic [2:0] bus_iface_state,
  output logic [1:0] bus_dir,
  output logic cycle_valid_n,
  output logic [2:0] queue_byte_count
);
  logic [7:0] k_q;
  // The counter runs outside runs too, so idle fields change every cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_running <= 1'b0;
      k_q <= 8'h00;
    end
    else
    begin
      prog_running <= run_en;
      k_q <= (run_en && !prog_running) ? 8'h00 : k_q + 8'h01;
    end
  end
  assign trace_stop = prog_running && (k_q == stop_k);
  assign bus_addr = 24'h100000 + {16'h0000, k_q};
  assign bus_data = 16'hC000 ^ {8'h00, k_q};
  assign bus_width16 = ~k_q[3];
  assign high_byte_enable_n = ~k_q[0];
  assign bus_iface_state = 3'(k_q % 8'h07);
  assign bus_dir = 2'(k_q % 8'h03);
  assign cycle_valid_n = k_q[2];
  assign queue_byte_count = 3'(k_q % 8'h05);
endmodule : bct_target_model

// ===== tb/bct_recorder_tb.sv
// Self-checking bench for the bus cycle trace recorder.
`timescale 1ns/1ps
module bct_recorder_tb;
  import bct_pkg::*;
  typedef struct {
    int len;
    logic [15:0] dly;
    logic [7:0] sk;
    logic [31:0] idx;
    logic [7:0] ek;
    logic [31:0] cnt;
  } bct_row_t;
  bct_row_t rows [6] = '{
    '{10, 16'h0000, 8'h63, 32'h00000000, 8'h09, 32'h0000000A},
    '{10, 16'h0000, 8'h63, 32'hFFFFFFF7, 8'h00, 32'h0000000A},
    '{70, 16'h0000, 8'h63, 32'hFFFFFFC1, 8'h06, 32'h00000040},
    '{20, 16'h0000, 8'h04, 32'h00000000, 8'h04, 32'h00000005},
    '{20, 16'h0003, 8'h05, 32'h00000003, 8'h08, 32'h00000009},
    '{20, 16'h0003, 8'h05, 32'hFFFFFFFB, 8'h00, 32'h00000009}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_en = 1'b0;
  logic [7:0] stop_k = 8'h63;
  logic prog_running, trace_stop, bus_width16, high_byte_enable_n, cycle_valid_n;
  logic [23:0] bus_addr;
  logic [15:0] bus_data;
  logic [2:0] bus_iface_state, queue_byte_count;
  logic [1:0] bus_dir;
  logic capturing, frozen, rerr;
  logic [31:0] rdat;
  logic [31:0] est;
  int n_mismatch = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;
  bct_target_model u_bct_target_model (.clk(pclk), .rst_n(presetn), .run_en(run_en),
    .stop_k(stop_k), .prog_running(prog_running), .trace_stop(trace_stop),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_width16(bus_width16),
    .high_byte_enable_n(high_byte_enable_n), .bus_iface_state(bus_iface_state),
    .bus_dir(bus_dir), .cycle_valid_n(cycle_valid_n), .queue_byte_count(queue_byte_count));
  bct_recorder #(.MEM_AW(6)) u_bct_recorder (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_running(prog_running), .trace_stop(trace_stop),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_width16(bus_width16),
    .high_byte_enable_n(high_byte_enable_n), .bus_iface_state(bus_iface_state),
    .bus_dir(bus_dir), .cycle_valid_n(cycle_valid_n), .queue_byte_count(queue_byte_count),
    .capturing(capturing), .frozen(frozen));
  task report_and_stop;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      chk(32'h00000000, 32'h00000001);
    if (pready !== 1'b1)
      report_and_stop();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Expected upper sample word for run cycle k of the target model.
  function automatic logic [31:0] ehi(input logic [7:0] k);
    ehi = {5'h00, 3'(k % 8'h05), k[2], 2'(k % 8'h03), 3'(k % 8'h07), ~k[0], ~k[3],
      16'hC000 ^ {8'h00, k}};
  endfunction : ehi
  task rd_next(input logic [7:0] k);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, BCT_OFS_STATUS, 32'h00000000);
      n++;
    end
    while (rdat[BCT_ST_AVAIL] !== 1'b1 && n < 20);
    chk({31'h00000000, rdat[BCT_ST_AVAIL]}, 32'h00000001);
    if (rdat[BCT_ST_AVAIL] !== 1'b1)
      report_and_stop();
    apb(1'b0, BCT_OFS_SAMPLE_LO, 32'h00000000);
    chk(rdat, 32'h00100000 + {24'h000000, k});
    apb(1'b0, BCT_OFS_SAMPLE_HI, 32'h00000000);
    chk(rdat, ehi(k));
  endtask : rd_next
  task run(input int len);
    int n;
    run_en <= 1'b1;
    repeat (len) @(posedge pclk);
    run_en <= 1'b0;
    n = 0;
    while (frozen !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h00000000, frozen}, 32'h00000001);
    if (frozen !== 1'b1)
      report_and_stop();
  endtask : run
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, BCT_OFS_CTRL, 32'h00000000);
    chk(rdat, {16'h0000, BCT_RST_DELAY});
    apb(1'b0, BCT_OFS_STATUS, 32'h00000000);
    chk(rdat, 32'h00000000);
    apb(1'b0, 8'h1C, 32'h00000000);
    chk({rdat[30:0], rerr}, 32'h00000001);
    foreach (rows[i])
    begin
      apb(1'b1, BCT_OFS_CTRL, {16'h0000, rows[i].dly});
      stop_k <= rows[i].sk;
      run(rows[i].len);
      apb(1'b0, BCT_OFS_COUNT, 32'h00000000);
      chk(rdat, rows[i].cnt);
      apb(1'b0, BCT_OFS_POST, 32'h00000000);
      chk(rdat, {16'h0000, rows[i].dly});
      // Frozen, delay mode only after a delayed stop, full only once the memory wrapped.
      est = {26'h0000000, rows[i].dly != 16'h0000, 1'b0, rows[i].cnt == 32'h00000040, 3'h4};
      apb(1'b0, BCT_OFS_STATUS, 32'h00000000);
      chk(rdat, est);
      apb(1'b1, BCT_OFS_RD_INDEX, rows[i].idx);
      rd_next(rows[i].ek);
    end
    // Sequential readout after a plain run walks every field code.
    apb(1'b1, BCT_OFS_CTRL, 32'h00000000);
    stop_k <= 8'h63;
    run(10);
    apb(1'b1, BCT_OFS_RD_INDEX, 32'hFFFFFFF7);
    for (int k = 0; k < 10; k++)
      rd_next(8'(k));
    // A reset in mid-run must drop capture at once.
    run_en <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h00000000, capturing, frozen}, 32'h00000000);
    presetn <= 1'b1;
    run_en <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h00000000, capturing, frozen}, 32'h00000000);
    apb(1'b0, BCT_OFS_COUNT, 32'h00000000);
    chk(rdat, 32'h00000000);
    report_and_stop();
  end
endmodule : bct_recorder_tb
